// file: rtl/duart_consts.svh
`ifndef DUART_CONSTS_SVH
`define DUART_CONSTS_SVH
// register indices; byte address is four times the index
`define DUART_IDX_POWER   8'h87
`define DUART_IDX_CTRL_B  8'h8e
`define DUART_IDX_DATA_B  8'h8f
`define DUART_IDX_OPTION  8'h94
`define DUART_IDX_CTRL_A  8'h98
`define DUART_IDX_DATA_A  8'h99
`define DUART_IDX_RATE    8'h9a
// field positions
`define DUART_BIT_DOUBLE  7
`define DUART_BIT_HALF    7
`define DUART_BIT_MODE_HI 7
`define DUART_BIT_MODE_LO 6
`define DUART_BIT_FILTER  5
`define DUART_BIT_REN     4
`define DUART_BIT_TB8     3
`define DUART_BIT_RB8     2
`define DUART_BIT_TI      1
`define DUART_BIT_RI      0
`define DUART_BIT_TXSRC   0
`define DUART_BIT_RXSRC   1
// writable bits, reserved bits read zero
`define DUART_MASK_POWER  8'h8f
`define DUART_MASK_CTRL_B 8'h9f
`define DUART_MASK_OPTION 8'hbf
`define DUART_MASK_RATE   8'h03
// reset values
`define DUART_RST_BYTE    8'h00
// bit timing in ticks
`define DUART_OS_LAST_ASYNC 4'hf
`define DUART_OS_LAST_SHIFT 4'h1
`define DUART_SAMP_ASYNC    4'h7
`define DUART_SAMP_SHIFT    4'h1
`endif

// file: rtl/duart_pkg.sv
package duart_pkg;
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_ASYNC8_VAR,
    MODE_ASYNC9_FIX,
    MODE_ASYNC9_VAR
  } duart_mode_t;
endpackage

// file: rtl/duart_ch_if.sv
`timescale 1ns/100ps
interface duart_ch_if;
  logic       tx_tick;
  logic       rx_tick;
  logic [3:0] os_last;
  logic [3:0] samp_at;
  logic       m0;
  logic       nine;
  logic       tx_start;
  logic [7:0] tx_data;
  logic       tx_bit8;
  logic       tx_line;
  logic       tx_sclk;
  logic       tx_busy;
  logic       tx_done;
  logic       rx_en;
  logic       rx_go;
  logic       rx_line;
  logic       rx_sclk;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_bit8;
  logic       rx_stop;
  modport ctl (output tx_tick, rx_tick, os_last, samp_at, m0, nine,
               tx_start, tx_data, tx_bit8, rx_en, rx_go, rx_line,
               input tx_line, tx_sclk, tx_busy, tx_done, rx_sclk,
               rx_done, rx_data, rx_bit8, rx_stop);
  modport txe (input tx_tick, os_last, m0, nine, tx_start, tx_data,
               tx_bit8, output tx_line, tx_sclk, tx_busy, tx_done);
  modport rxe (input rx_tick, os_last, samp_at, m0, nine, rx_en, rx_go,
               rx_line, output rx_sclk, rx_done, rx_data, rx_bit8,
               rx_stop);
endinterface

// file: rtl/duart_tx.sv
`timescale 1ns/100ps
module duart_tx (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  duart_ch_if.txe  ch
);
  logic [10:0] sh_ff;
  logic [3:0]  cnt_ff;
  logic [3:0]  left_ff;
  logic        busy_ff;
  wire  [3:0]  nbits   = ch.m0 ? 4'h8 : (ch.nine ? 4'hb : 4'ha);
  wire         bit_end = busy_ff & ch.tx_tick & (cnt_ff == ch.os_last);
  wire  [10:0] frame   = ch.m0 ? {3'h7, ch.tx_data} :
    {(ch.nine ? {1'b1, ch.tx_bit8} : 2'h3), ch.tx_data, 1'b0};
  assign ch.tx_line = sh_ff[0];
  assign ch.tx_busy = busy_ff;
  assign ch.tx_sclk = (busy_ff & ch.m0) ? cnt_ff[0] : 1'b1;
  assign ch.tx_done = bit_end & (left_ff == (ch.m0 ? 4'h1 : 4'h2));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_ff   <= 11'h7ff;
      cnt_ff  <= 4'h0;
      left_ff <= 4'h0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      if (ch.tx_start) begin
        sh_ff   <= frame;
        cnt_ff  <= 4'h0;
        left_ff <= nbits;
        busy_ff <= 1'b1;
      end else if (busy_ff & ch.tx_tick) begin
        cnt_ff <= bit_end ? 4'h0 : cnt_ff + 4'h1;
        if (bit_end) begin
          sh_ff   <= {1'b1, sh_ff[10:1]};
          left_ff <= left_ff - 4'h1;
          busy_ff <= (left_ff != 4'h1);
        end
      end
    end
  end
endmodule

// file: rtl/duart_rx.sv
`timescale 1ns/100ps
module duart_rx (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  duart_ch_if.rxe  ch
);
  logic [10:0] sh_ff;
  logic [3:0]  cnt_ff;
  logic [3:0]  left_ff;
  logic        busy_ff;
  logic        prev_ff;
  logic        done_ff;
  logic [7:0]  data_ff;
  logic        bit8_ff;
  logic        stop_ff;
  wire  [3:0]  nbits  = ch.m0 ? 4'h8 : (ch.nine ? 4'hb : 4'ha);
  // shift mode waits for the flag of the last byte to clear before rearming
  wire         go     = ~busy_ff & ch.rx_en & (ch.m0 ?
    (ch.rx_go & ~done_ff) : (prev_ff & ~ch.rx_line));
  wire         samp   = busy_ff & ch.rx_tick & (cnt_ff == ch.samp_at);
  wire         wrap   = cnt_ff == ch.os_last;
  wire         bad_st = ~ch.m0 & (left_ff == nbits) & ch.rx_line;
  wire         last   = left_ff == 4'h1;
  wire  [10:0] nxt_sh = {ch.rx_line, sh_ff[10:1]};
  wire  [10:0] frame  = ch.nine ? nxt_sh : {1'b0, nxt_sh[10:1]};
  assign ch.rx_sclk = (busy_ff & ch.m0) ? cnt_ff[0] : 1'b1;
  assign ch.rx_done = done_ff;
  assign ch.rx_data = data_ff;
  assign ch.rx_bit8 = bit8_ff;
  assign ch.rx_stop = stop_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_ff   <= 11'h000;
      cnt_ff  <= 4'h0;
      left_ff <= 4'h0;
      busy_ff <= 1'b0;
      prev_ff <= 1'b1;
      done_ff <= 1'b0;
      data_ff <= 8'h00;
      bit8_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= ch.rx_line;
      done_ff <= 1'b0;
      if (go) begin
        busy_ff <= 1'b1;
        cnt_ff  <= 4'h0;
        left_ff <= nbits;
      end else if (busy_ff & ~ch.rx_en) begin
        busy_ff <= 1'b0;
      end else if (busy_ff & ch.rx_tick) begin
        cnt_ff <= wrap ? 4'h0 : cnt_ff + 4'h1;
        if (samp) begin
          sh_ff   <= nxt_sh;
          left_ff <= left_ff - 4'h1;
          busy_ff <= ~(bad_st | last);
          done_ff <= last;
          if (last) begin
            data_ff <= ch.m0 ? nxt_sh[10:3] : frame[8:1];
            bit8_ff <= frame[9];
            stop_ff <= ch.nine ? frame[10] : frame[9];
          end
        end
      end
    end
  end
endmodule

// file: rtl/duart_top.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "duart_consts.svh"
module duart_top (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output wire logic [31:0] avs_readdata,
  output wire logic        avs_waitrequest,
  input  wire logic        t1_overflow,
  input  wire logic        t2_overflow,
  output wire logic        txd_a_o,
  output wire logic        txd_a_oe,
  input  wire logic        txd_a_i,
  input  wire logic        rxd_a,
  output wire logic        shift_clk_a,
  output wire logic        txd_b,
  input  wire logic        rxd_b
);
  import duart_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] power_ff;
  logic [7:0] option_ff;
  logic [7:0] ctl_a_ff;
  logic [7:0] ctl_b_ff;
  logic [7:0] rate_ff;
  logic [7:0] rx_buf_a_ff;
  logic [7:0] rx_buf_b_ff;
  logic [7:0] readdata_ff;
  logic       ack_ff;
  logic       t1_half_ff;
  logic [1:0] fix_cnt_ff;
  logic [7:0] nxt_ctl_a;
  logic [7:0] nxt_ctl_b;

  duart_ch_if ch_a ();
  duart_ch_if ch_b ();

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  wire       req    = avs_read | avs_write;
  wire [7:0] idx    = avs_address[9:2];
  wire [7:0] wbyte  = avs_writedata[7:0];
  // one wait cycle, then the transfer completes
  wire       wr_go  = avs_write & ack_ff & avs_byteenable[0];
  wire       rd_cap = avs_read & ~ack_ff;

  wire sel_power  = idx == `DUART_IDX_POWER;
  wire sel_ctl_b  = idx == `DUART_IDX_CTRL_B;
  wire sel_data_b = idx == `DUART_IDX_DATA_B;
  wire sel_option = idx == `DUART_IDX_OPTION;
  wire sel_ctl_a  = idx == `DUART_IDX_CTRL_A;
  wire sel_data_a = idx == `DUART_IDX_DATA_A;
  wire sel_rate   = idx == `DUART_IDX_RATE;
  wire low_lanes  = avs_address[1:0] == 2'h0;

  wire wr_power  = wr_go & low_lanes & sel_power;
  wire wr_ctl_b  = wr_go & low_lanes & sel_ctl_b;
  wire wr_data_b = wr_go & low_lanes & sel_data_b;
  wire wr_option = wr_go & low_lanes & sel_option;
  wire wr_ctl_a  = wr_go & low_lanes & sel_ctl_a;
  wire wr_data_a = wr_go & low_lanes & sel_data_a;
  wire wr_rate   = wr_go & low_lanes & sel_rate;

  // read of a data buffer shows the receive side only
  wire [7:0] rd_byte =
    ~low_lanes ? 8'h00 :
    sel_power  ? power_ff :
    sel_ctl_b  ? ctl_b_ff :
    sel_data_b ? rx_buf_b_ff :
    sel_option ? option_ff :
    sel_ctl_a  ? ctl_a_ff :
    sel_data_a ? rx_buf_a_ff :
    sel_rate   ? rate_ff : 8'h00;

  assign avs_waitrequest = req & ~(ack_ff & ce);
  assign avs_readdata    = {24'h000000, readdata_ff};

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire double_baud_a          = power_ff[`DUART_BIT_DOUBLE];
  wire half_duplex_pin_enable = option_ff[`DUART_BIT_HALF];
  wire port_mode_hi_bit       = ctl_a_ff[`DUART_BIT_MODE_HI];
  wire port_mode_lo_bit       = ctl_a_ff[`DUART_BIT_MODE_LO];
  wire address_filter_enable  = ctl_a_ff[`DUART_BIT_FILTER];
  wire rx_enable_a            = ctl_a_ff[`DUART_BIT_REN];
  wire tx_ninth_bit_a         = ctl_a_ff[`DUART_BIT_TB8];
  wire rx_done_flag_a         = ctl_a_ff[`DUART_BIT_RI];
  wire frame_len_select_b     = ctl_b_ff[`DUART_BIT_MODE_HI];
  wire rx_enable_b            = ctl_b_ff[`DUART_BIT_REN];
  wire tx_ninth_bit_b         = ctl_b_ff[`DUART_BIT_TB8];
  wire rx_done_flag_b         = ctl_b_ff[`DUART_BIT_RI];
  wire tx_rate_source         = rate_ff[`DUART_BIT_TXSRC];
  wire rx_rate_source         = rate_ff[`DUART_BIT_RXSRC];

  duart_mode_t mode_a;
  assign mode_a = duart_mode_t'({port_mode_hi_bit, port_mode_lo_bit});

  wire m0_a    = mode_a == MODE_SHIFT;
  wire fixed_a = mode_a == MODE_ASYNC9_FIX;
  wire nine_a  = port_mode_hi_bit;

  // ----------------------------------------------------------------
  // rate ticks, sixteen per bit in the frame modes
  // ----------------------------------------------------------------
  // fixed rate: a tick every 4 clocks, or every 2 when doubled
  wire fix_tick  = double_baud_a ? fix_cnt_ff[0] : &fix_cnt_ff;
  // timer1 overflows halved unless doubled
  wire t1_tick_a = t1_overflow & (double_baud_a | t1_half_ff);
  wire var_tx_a  = tx_rate_source ? t2_overflow : t1_tick_a;
  wire var_rx_a  = rx_rate_source ? t2_overflow : t1_tick_a;

  assign ch_a.tx_tick = m0_a | (fixed_a ? fix_tick : var_tx_a);
  assign ch_a.rx_tick = m0_a | (fixed_a ? fix_tick : var_rx_a);
  // shift mode: every clock counts, two clocks per bit
  assign ch_a.os_last = m0_a ? `DUART_OS_LAST_SHIFT : `DUART_OS_LAST_ASYNC;
  assign ch_a.samp_at = m0_a ? `DUART_SAMP_SHIFT : `DUART_SAMP_ASYNC;
  assign ch_a.m0      = m0_a;
  assign ch_a.nine    = nine_a;

  // port b: every timer1 overflow, doubling fixed on
  assign ch_b.tx_tick = t1_overflow;
  assign ch_b.rx_tick = t1_overflow;
  assign ch_b.os_last = `DUART_OS_LAST_ASYNC;
  assign ch_b.samp_at = `DUART_SAMP_ASYNC;
  assign ch_b.m0      = 1'b0;
  assign ch_b.nine    = frame_len_select_b;

  // ----------------------------------------------------------------
  // transmit side
  // ----------------------------------------------------------------
  // a write to a data buffer starts the frame at once
  assign ch_a.tx_start = wr_data_a;
  assign ch_a.tx_data  = wbyte;
  assign ch_a.tx_bit8  = tx_ninth_bit_a;
  assign ch_b.tx_start = wr_data_b;
  assign ch_b.tx_data  = wbyte;
  assign ch_b.tx_bit8  = tx_ninth_bit_b;

  // one-wire: drive the shared pin only while sending
  assign txd_a_o  = ch_a.tx_line;
  assign txd_a_oe = ~half_duplex_pin_enable | ch_a.tx_busy;
  assign txd_b    = ch_b.tx_line;
  assign shift_clk_a = ~m0_a ? 1'b1 :
    (ch_a.tx_busy ? ch_a.tx_sclk : ch_a.rx_sclk);

  // ----------------------------------------------------------------
  // receive side
  // ----------------------------------------------------------------
  // own transmission is not heard back on the shared pin
  wire shared_in = ch_a.tx_busy ? 1'b1 : txd_a_i;
  assign ch_a.rx_line = (half_duplex_pin_enable & ~m0_a) ?
    shared_in : rxd_a;
  assign ch_a.rx_en = rx_enable_a;
  assign ch_a.rx_go = m0_a & ~rx_done_flag_a;
  assign ch_b.rx_line = rxd_b;
  assign ch_b.rx_en   = rx_enable_b;
  assign ch_b.rx_go   = 1'b0;

  // filter: 9-bit frames need ninth bit 1, 8-bit a valid stop
  wire pass_a = m0_a | ~address_filter_enable |
    (nine_a ? ch_a.rx_bit8 : ch_a.rx_stop);
  // an unread byte is kept; a new frame behind it is lost
  wire load_a = ch_a.rx_done & ~rx_done_flag_a & pass_a;
  wire rb8_a  = nine_a ? ch_a.rx_bit8 : ch_a.rx_stop;
  wire load_b = ch_b.rx_done & ~rx_done_flag_b;

  // ----------------------------------------------------------------
  // control register next values, a hardware set beats a clear
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctl_a = ctl_a_ff;
    if (wr_ctl_a) begin
      nxt_ctl_a = wbyte;
    end
    if (ch_a.tx_done) begin
      nxt_ctl_a[`DUART_BIT_TI] = 1'b1;
    end
    if (load_a) begin
      nxt_ctl_a[`DUART_BIT_RI] = 1'b1;
    end
    if (load_a & ~m0_a) begin
      nxt_ctl_a[`DUART_BIT_RB8] = rb8_a;
    end
  end

  always_comb begin
    nxt_ctl_b = ctl_b_ff;
    if (wr_ctl_b) begin
      nxt_ctl_b = wbyte & `DUART_MASK_CTRL_B;
    end
    if (ch_b.tx_done) begin
      nxt_ctl_b[`DUART_BIT_TI] = 1'b1;
    end
    if (load_b) begin
      nxt_ctl_b[`DUART_BIT_RI] = 1'b1;
    end
    if (load_b & frame_len_select_b) begin
      nxt_ctl_b[`DUART_BIT_RB8] = ch_b.rx_bit8;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_ff      <= 1'b0;
      readdata_ff <= `DUART_RST_BYTE;
    end else if (ce) begin
      ack_ff <= req & ~ack_ff;
      if (rd_cap) begin
        readdata_ff <= rd_byte;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_ff  <= `DUART_RST_BYTE;
      option_ff <= `DUART_RST_BYTE;
      rate_ff   <= `DUART_RST_BYTE;
    end else if (ce) begin
      if (wr_power) begin
        power_ff <= wbyte & `DUART_MASK_POWER;
      end
      if (wr_option) begin
        option_ff <= wbyte & `DUART_MASK_OPTION;
      end
      if (wr_rate) begin
        rate_ff <= wbyte & `DUART_MASK_RATE;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_a_ff <= `DUART_RST_BYTE;
      ctl_b_ff <= `DUART_RST_BYTE;
    end else if (ce) begin
      ctl_a_ff <= nxt_ctl_a;
      ctl_b_ff <= nxt_ctl_b;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_buf_a_ff <= `DUART_RST_BYTE;
      rx_buf_b_ff <= `DUART_RST_BYTE;
    end else if (ce) begin
      if (load_a) begin
        rx_buf_a_ff <= ch_a.rx_data;
      end
      if (load_b) begin
        rx_buf_b_ff <= ch_b.rx_data;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      t1_half_ff <= 1'b0;
      fix_cnt_ff <= 2'h0;
    end else if (ce) begin
      fix_cnt_ff <= fix_cnt_ff + 2'h1;
      if (t1_overflow) begin
        t1_half_ff <= ~t1_half_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial engines
  // ----------------------------------------------------------------
  duart_tx u_tx_a (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .ch    (ch_a.txe)
  );

  duart_rx u_rx_a (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .ch    (ch_a.rxe)
  );

  duart_tx u_tx_b (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .ch    (ch_b.txe)
  );

  duart_rx u_rx_b (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .ch    (ch_b.rxe)
  );

endmodule

// file: sim/duart_top_asserts.sv
`timescale 1ns/100ps
`include "duart_consts.svh"
module duart_top_asserts (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        t1_overflow,
  input wire logic        t2_overflow,
  input wire logic        txd_a_o,
  input wire logic        txd_a_oe,
  input wire logic        txd_a_i,
  input wire logic        rxd_a,
  input wire logic        shift_clk_a,
  input wire logic        txd_b,
  input wire logic        rxd_b
);
  // ----------------------------------------
  // bus answer, readback and line framing
  // ----------------------------------------
  wire req  = avs_read | avs_write;
  wire ack  = req & ~avs_waitrequest;
  wire wr_b = avs_write & ack & avs_byteenable[0] &
              (avs_address == {`DUART_IDX_DATA_B, 2'b00});
  wire rd_b = avs_read & ack &
              (avs_address == {`DUART_IDX_CTRL_B, 2'b00});

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_wait_once: assert property (req && avs_waitrequest && ce
    |=> !avs_waitrequest || !ce) else $error("bus wait too long");
  a_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_rd_upper: assert property (avs_read && ack
    |-> avs_readdata[31:8] == 24'h0) else $error("readdata upper set");
  a_rd_unmapped: assert property (avs_read && ack
    && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
    else $error("misaligned read not zero");
  a_rsv_b_zero: assert property (rd_b
    |-> avs_readdata[6:5] == 2'h0) else $error("ctrl_b reserved set");
  a_rd_hold: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("readdata moved");
  a_start_next: assert property (wr_b |=> !txd_b)
    else $error("port b start bit late");
  a_start_len: assert property ($fell(txd_b)
    |-> !txd_b [*8]) else $error("port b bit too short");
  a_shift_low: assert property ($fell(shift_clk_a)
    |=> shift_clk_a) else $error("shift clock low too long");
  a_shift_hold: assert property ($rose(shift_clk_a)
    |-> $stable(txd_a_o)) else $error("shift data moved");

  cover property (wr_b);
  cover property ($fell(shift_clk_a));
  cover property ($fell(txd_a_oe));
endmodule

// file: sim/duart_remote.sv
`timescale 1ns/100ps
module duart_remote (
  input  wire logic clock,
  input  wire logic line_in,
  output logic      line_out
);
  // ----------------------------------------
  // remote transceiver, one line each way
  // ----------------------------------------
  int unsigned bit_cyc = 32;
  int unsigned got     = 0;
  logic        nine    = 1'b0;
  logic [8:0]  word;
  logic        stop;

  initial line_out = 1'b1;

  always begin
    @(negedge line_in);
    repeat (bit_cyc / 2) @(posedge clock);
    if (line_in === 1'b0) begin
      for (int i = 0; i < 9; i++) begin
        if (i < 8 || nine) begin
          repeat (bit_cyc) @(posedge clock);
          word[i] = line_in;
        end
      end
      repeat (bit_cyc) @(posedge clock);
      stop = line_in;
      got++;
    end
  end

  task automatic send(input logic [8:0] d, input logic stp);
    logic [10:0] f;
    f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= f[i];
      repeat (bit_cyc) @(posedge clock);
    end
    line_out <= 1'b1;
  endtask
endmodule

// file: sim/duart_top_test.sv
`timescale 1ns/100ps
`include "duart_consts.svh"
module duart_top_test;
  import duart_pkg::*;
  logic        clock;
  logic        rst;
  logic        ce;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        t1_overflow = 1'b0;
  logic        t2_overflow = 1'b0;
  logic        txd_a_o;
  logic        txd_a_oe;
  logic        txd_a_i;
  logic        rxd_a;
  logic        shift_clk_a;
  logic        txd_b;
  logic        rxd_b;
  logic        rem_a_out;
  logic        hd = 1'b0;
  int          failures = 0;
  int          checks = 0;
  int          cyc = 0;
  int          t2_cnt = 0;

  // shared pin: open collector when one-wire is on
  assign txd_a_i = (txd_a_oe ? txd_a_o : 1'b1) & (hd ? rem_a_out : 1'b1);
  assign rxd_a   = hd ? 1'b1 : rem_a_out;

  duart_top dut (.clock, .rst, .ce, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .t1_overflow, .t2_overflow, .txd_a_o, .txd_a_oe, .txd_a_i, .rxd_a,
    .shift_clk_a, .txd_b, .rxd_b);
  duart_remote rem_a (.clock, .line_in(txd_a_i), .line_out(rem_a_out));
  duart_remote rem_b (.clock, .line_in(txd_b), .line_out(rxd_b));

  // ----------------------------------------
  // clock, timers, timeout, bus access
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    t1_overflow <= ~t1_overflow;
    t2_cnt <= (t2_cnt == 2) ? 0 : t2_cnt + 1;
    t2_overflow <= (t2_cnt == 2);
    if (cyc == 40000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [9:0] adr,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clock);
    avs_address   <= adr;
    avs_writedata <= {24'h0, wd};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, {idx, 2'b00}, d, x);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    bus(1'b0, {idx, 2'b00}, 8'h00, v);
  endtask

  task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp,
                        input string what);
    logic [7:0] v;
    rd(idx, v);
    check(what, exp, v);
  endtask

  task automatic wait_got(input logic b, input int old);
    while ((b ? rem_b.got : rem_a.got) == old) begin
      @(posedge clock);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] x;
    chk_rd(`DUART_IDX_CTRL_A, 8'h00, "ctrl_a reset");
    chk_rd(`DUART_IDX_CTRL_B, 8'h00, "ctrl_b reset");
    wr(`DUART_IDX_POWER, 8'hff);
    chk_rd(`DUART_IDX_POWER, 8'h8f, "power");
    wr(`DUART_IDX_OPTION, 8'h7f);
    chk_rd(`DUART_IDX_OPTION, 8'h3f, "option");
    wr(`DUART_IDX_CTRL_B, 8'he0);
    chk_rd(`DUART_IDX_CTRL_B, 8'h80, "ctrl_b");
    avs_byteenable <= 4'he;
    wr(`DUART_IDX_POWER, 8'h00);
    avs_byteenable <= 4'hf;
    chk_rd(`DUART_IDX_POWER, 8'h8f, "byteenable");
    bus(1'b1, {`DUART_IDX_POWER, 2'b01}, 8'h00, x);
    chk_rd(`DUART_IDX_POWER, 8'h8f, "misaligned");
    bus(1'b0, {`DUART_IDX_POWER, 2'b10}, 8'h00, x);
    check("misaligned rd", 8'h00, x);
    chk_rd(8'h80, 8'h00, "unmapped");
    wr(`DUART_IDX_POWER, 8'h00);
    wr(`DUART_IDX_OPTION, 8'h00);
    $display("regs test done");
  endtask

  task automatic t_port_b();
    int         old;
    logic [7:0] d;
    for (int n = 0; n < 2; n++) begin
      d = n ? 8'h3a : 8'hc5;
      rem_b.nine = n[0];
      wr(`DUART_IDX_CTRL_B, n ? 8'h98 : 8'h18);
      old = rem_b.got;
      wr(`DUART_IDX_DATA_B, d);
      chk_rd(`DUART_IDX_CTRL_B, n ? 8'h98 : 8'h18, "b early");
      wait_got(1'b1, old);
      check("b tx data", d, rem_b.word[7:0]);
      if (n) check("b tx ninth", 8'h01, {7'h0, rem_b.word[8]});
      chk_rd(`DUART_IDX_CTRL_B, {n[0], 4'h3, 3'h2}, "b tx flag");
      rem_b.send({1'b1, ~d}, 1'b1);
      chk_rd(`DUART_IDX_CTRL_B, {n[0], 4'h3, n[0], 2'h3}, "b rx");
      chk_rd(`DUART_IDX_DATA_B, ~d, "b rx data");
    end
    wr(`DUART_IDX_CTRL_B, 8'h00);
    rem_b.send(9'h1f0, 1'b1);
    chk_rd(`DUART_IDX_CTRL_B, 8'h00, "b rx off");
    $display("port b test done");
  endtask

  task automatic t_port_a();
    duart_mode_t md [5] = '{MODE_ASYNC9_FIX, MODE_ASYNC9_FIX,
      MODE_ASYNC8_VAR, MODE_ASYNC8_VAR, MODE_ASYNC9_VAR};
    int          per [5] = '{64, 32, 64, 32, 48};
    logic [4:0]  dbl = 5'b01010;
    logic [4:0]  src = 5'b10000;
    logic        nine;
    logic [7:0]  d;
    int          old;
    for (int i = 0; i < 5; i++) begin
      d = 8'h96 ^ i[7:0];
      nine = md[i][1];
      rem_a.nine = nine;
      rem_a.bit_cyc = per[i];
      wr(`DUART_IDX_POWER, {dbl[i], 7'h0});
      wr(`DUART_IDX_RATE, {6'h0, src[i], src[i]});
      wr(`DUART_IDX_CTRL_A, {md[i], 6'h18});
      old = rem_a.got;
      wr(`DUART_IDX_DATA_A, d);
      wait_got(1'b0, old);
      check("a tx data", d, rem_a.word[7:0]);
      if (nine) check("a tx ninth", 8'h01, {7'h0, rem_a.word[8]});
      rem_a.send({1'b0, ~d}, 1'b1);
      chk_rd(`DUART_IDX_CTRL_A, {md[i], 3'h3, ~nine, 2'h3}, "a flags");
      chk_rd(`DUART_IDX_DATA_A, ~d, "a rx data");
    end
    $display("port a modes test done");
  endtask

  task automatic t_filter();
    logic [7:0] v;
    rem_a.nine = 1'b1;
    wr(`DUART_IDX_CTRL_A, 8'hf0);
    rem_a.send(9'h033, 1'b1);
    rd(`DUART_IDX_CTRL_A, v);
    check("filter ninth 0", 8'h00, {7'h0, v[0]});
    rem_a.send(9'h133, 1'b1);
    chk_rd(`DUART_IDX_CTRL_A, 8'hf5, "filter ninth 1");
    rem_a.nine = 1'b0;
    wr(`DUART_IDX_CTRL_A, 8'h70);
    rem_a.send(9'h044, 1'b0);
    rd(`DUART_IDX_CTRL_A, v);
    check("filter bad stop", 8'h00, {7'h0, v[0]});
    rem_a.send(9'h044, 1'b1);
    rd(`DUART_IDX_CTRL_A, v);
    check("filter good stop", 8'h01, {7'h0, v[0]});
    $display("filter test done");
  endtask

  task automatic t_one_wire();
    int old;
    wr(`DUART_IDX_OPTION, 8'h80);
    hd <= 1'b1;
    wr(`DUART_IDX_CTRL_A, 8'h50);
    rem_a.send(9'h0a7, 1'b1);
    chk_rd(`DUART_IDX_CTRL_A, 8'h55, "one wire flag");
    chk_rd(`DUART_IDX_DATA_A, 8'ha7, "one wire rx");
    old = rem_a.got;
    wr(`DUART_IDX_DATA_A, 8'h3c);
    wait_got(1'b0, old);
    check("one wire tx", 8'h3c, rem_a.word[7:0]);
    wr(`DUART_IDX_OPTION, 8'h00);
    hd <= 1'b0;
    $display("one wire test done");
  endtask

  task automatic t_shift();
    logic [7:0] sh;
    time        ta;
    time        tb;
    // let the last frame's stop bit end first
    repeat (48) @(posedge clock);
    wr(`DUART_IDX_CTRL_A, 8'h00);
    fork
      wr(`DUART_IDX_DATA_A, 8'h6d);
      for (int k = 0; k < 8; k++) begin
        @(posedge shift_clk_a);
        if (k == 0) ta = $time;
        tb = $time;
        sh = {txd_a_o, sh[7:1]};
      end
    join
    check("shift data", 8'h6d, sh);
    check("shift period", 8'h38, 8'(tb - ta));
    chk_rd(`DUART_IDX_CTRL_A, 8'h02, "shift tx flag");
    wr(`DUART_IDX_CTRL_A, 8'h10);
    repeat (24) @(posedge clock);
    chk_rd(`DUART_IDX_CTRL_A, 8'h11, "shift rx flag");
    chk_rd(`DUART_IDX_DATA_A, 8'hff, "shift rx data");
    $display("shift test done");
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_port_b();
    t_port_a();
    t_filter();
    t_one_wire();
    t_shift();
    end_sim();
  end
endmodule

bind duart_top duart_top_asserts u_chk (.clock, .rst, .ce, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .t1_overflow, .t2_overflow, .txd_a_o, .txd_a_oe,
  .txd_a_i, .rxd_a, .shift_clk_a, .txd_b, .rxd_b);
